// file: rtl/sfrs_ctrl.sv
// search raster control with AHB-Lite registers and telemetry word
//
// Functional notes
// [RQ1] continue while tracking: resume two below acquisition
// [RQ2] raster done without star: restart at start
// [RQ3] continue while searching: skip two Y steps
// [RQ4] fine offsets take effect immediately
// [RQ5] coarse X/size at line end, Y/size field end
// [RQ6] commander changes mode to replace raster early
// [RQ7] tracking: only rate, fine, spacing update
// [RQ8] presence lost: freeze scan and error outputs
// [RQ9] field mode: each word gate advances dwell
// [RQ10] field mode tracks only with permit bit
// [RQ11] offset: 7-bit coarse, 5-bit fine per axis
// [RQ12] coarse two's complement, fine always positive
// [RQ13] 2*size+1 dwells per line and lines
// [RQ14] commander sets mode 1x, permit low mapping
// [RQ15] each step is one coarse count
// [RQ16] 56-bit word: mode, coordinates, magnitude
// [RQ17] line end: return X, step Y, blank dwell
// [RQ18] search-and-track dwell timed internally
// [RQ19] two-bit code picks one of four thresholds
// [RQ20] mode change abandons raster, restarts fresh
// [RQ21] first exceeding dwell sets flag, latches point
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sfrs_ctrl
    import sfrs_pkg::*;
#(
    parameter int DWELL_CYCLES = DWELL_CYC
) (
    input  wire logic         hclk,               // clock
    input  wire logic         hresetn,            // async reset, active low
    input  wire logic         hsel,               // slave select
    input  wire logic [31:0]  haddr,              // address
    input  wire logic [1:0]   htrans,             // transfer type
    input  wire logic         hwrite,             // write
    input  wire logic [2:0]   hsize,              // size, word only
    input  wire logic [31:0]  hwdata,             // write data
    input  wire logic         hready,             // bus ready
    output logic [31:0]       hrdata,             // read data
    output logic              hreadyout,          // always ready
    output logic              hresp,              // always okay
    input  wire logic         telemetry_word_gate, // word gate pin
    input  wire logic         tlm_shift_pin,      // shift pulse pin
    output logic              tlm_sdata,          // serial telemetry
    input  wire logic [14:0]  mag_count,          // star magnitude count
    input  wire logic         track_star_ok,      // track loop still sees star
    input  wire logic [11:0]  track_err_x,        // track loop X error
    input  wire logic [11:0]  track_err_y,        // track loop Y error
    output logic [11:0]       scan_x,             // search deflection X
    output logic [11:0]       scan_y,             // search deflection Y
    output logic              track_active,       // track deflection on
    output logic              track_hold,         // freeze track scan
    output logic              track_scan_rate_bit, // slow track when high
    output logic              scan_spacing_bit,   // underlap when high
    output logic              star_presence_flag, // star acquired
    output logic [11:0]       err_x_out,          // held X error
    output logic [11:0]       err_y_out           // held Y error
);
    // ==========================================================
    // bus slave
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] raster_cmd, next_raster_cmd;
    logic [6:0]  ctrl_cmd, next_ctrl_cmd;
    logic [31:0] next_hrdata;
    logic        cont_req;
    logic        addr_ok;
    sfrs_state_e state, next_state;
    logic [6:0]  x0_act, y0_act, next_x0_act, next_y0_act;
    logic [5:0]  szx, szy, next_szx, next_szy;
    logic [6:0]  dx, dy, next_dx, next_dy;
    logic [6:0]  acq_dx, acq_dy, next_acq_dx, next_acq_dy;
    logic [1:0]  mode_act, next_mode_act;
    logic        blank, next_blank;
    logic        presence, next_presence;
    logic [11:0] ex, ey, next_ex, next_ey;
    logic [7:0]  cx, cy;

    assign addr_ok = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        next_wr_pend = addr_ok && hwrite;
        next_wr_addr = haddr[7:0];
        next_raster_cmd = raster_cmd;
        next_ctrl_cmd = ctrl_cmd;
        cont_req = 1'b0;
        next_hrdata = hrdata;
        if (wr_pend) begin
            if (wr_addr == REG_RASTER) begin
                next_raster_cmd = {2'b00, hwdata[29:0]};
            end else if (wr_addr == REG_CTRL) begin
                next_ctrl_cmd = hwdata[6:0];
            end else if (wr_addr == REG_CONT) begin
                cont_req = 1'b1;
            end
        end
        if (addr_ok && !hwrite) begin
            if (haddr[7:0] == REG_RASTER) begin
                next_hrdata = raster_cmd;
            end else if (haddr[7:0] == REG_CTRL) begin
                next_hrdata = {25'h0, ctrl_cmd};
            end else if (haddr[7:0] == REG_STATUS) begin
                next_hrdata = {22'h0, acq_dy[1:0], blank, presence, mode_act, 2'b00, state};
            end else if (haddr[7:0] == REG_POS) begin
                next_hrdata = {4'h0, scan_y, 4'h0, scan_x};
            end else if (haddr[7:0] == REG_MAG) begin
                next_hrdata = {17'h0, mag_count};
            end else begin
                next_hrdata = 32'h0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            raster_cmd <= RASTER_RST;
            ctrl_cmd <= CTRL_RST;
            hrdata <= 32'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            raster_cmd <= next_raster_cmd;
            ctrl_cmd <= next_ctrl_cmd;
            hrdata <= next_hrdata;
        end
    end

    // ==========================================================
    // pin synchronisers and dwell timing
    logic [1:0]  gate_s, shift_s;
    logic        gate_d, shift_d, gate_p, shift_p;
    logic [14:0] timer, next_timer;
    logic        dwell_end;
    logic [1:0]  cmd_mode;
    logic [6:0]  x_lim, y_lim;
    logic [14:0] thr;
    logic        can_acq, acquire, line_end, field_end, mode_chg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_s <= 2'b00;
            shift_s <= 2'b00;
            gate_d <= 1'b0;
            shift_d <= 1'b0;
        end else begin
            gate_s <= {gate_s[0], telemetry_word_gate};
            shift_s <= {shift_s[0], tlm_shift_pin};
            gate_d <= gate_s[1];
            shift_d <= shift_s[1];
        end
    end
    assign gate_p = gate_s[1] && !gate_d;
    assign shift_p = shift_s[1] && !shift_d;

    assign cmd_mode = ctrl_cmd[MODE_LSB +: 2];
    assign x_lim = {szx, 1'b0};                                            // RQ13
    assign y_lim = {szy, 1'b0};                                            // RQ13
    // field mode dwells follow the word gate, search-and-track runs on the timer
    assign dwell_end = mode_act[1] ? gate_p : (timer == 15'h0);            // RQ9 RQ18
    always_comb begin
        case (ctrl_cmd[THR_SEL_LSB +: 2])                                  // RQ19
            2'b00: thr = THR_0;
            2'b01: thr = THR_1;
            2'b10: thr = THR_2;
            default: thr = THR_3;
        endcase
    end
    assign can_acq = (mode_act == MODE_SEARCH) || (mode_act[1] && ctrl_cmd[PERMIT_BIT]); // RQ10
    assign acquire = can_acq && !blank && (mag_count > thr);               // RQ21
    assign line_end = (dx == x_lim);
    assign field_end = (dy == y_lim);
    // a mode change waits while tracking; coarse and size fields wait too, fine, rate and spacing do not
    assign mode_chg = (cmd_mode != mode_act) && (state != ST_TRACK);       // RQ7 RQ20

    // ==========================================================
    // raster sequencer
    always_comb begin
        next_state = state;
        next_x0_act = x0_act;
        next_y0_act = y0_act;
        next_szx = szx;
        next_szy = szy;
        next_dx = dx;
        next_dy = dy;
        next_acq_dx = acq_dx;
        next_acq_dy = acq_dy;
        next_mode_act = mode_act;
        next_blank = blank;
        next_presence = presence;
        next_timer = (timer == 15'h0) ? 15'(DWELL_CYCLES - 1) : timer - 15'h1;
        if (mode_chg) begin
            next_mode_act = cmd_mode;
            next_state = (cmd_mode == MODE_PRIMARY) ? ST_IDLE : ST_SEARCH;  // RQ20
            next_x0_act = raster_cmd[XC_LSB +: COARSE_W];
            next_y0_act = raster_cmd[YC_LSB +: COARSE_W];
            next_szx = raster_cmd[SZ_LSB +: SIZE_W];
            next_szy = raster_cmd[SZ_LSB +: SIZE_W];
            next_dx = 7'h0;
            next_dy = 7'h0;
            next_blank = 1'b1;
            next_presence = 1'b0;
            next_timer = 15'(DWELL_CYCLES - 1);
        end else if (cont_req && state != ST_IDLE) begin
            // resume two lines below the acquisition point, or skip two lines
            next_dy = ((state == ST_TRACK) ? acq_dy : dy) + Y_SKIP;        // RQ1 RQ3
            if (state == ST_TRACK) begin
                next_dx = acq_dx;                                          // RQ1
                next_blank = 1'b1;
            end
            next_state = ST_SEARCH;
            next_presence = 1'b0;
            // a skip that carries past the 7-bit index also ends the raster
            if (next_dy > y_lim || next_dy < Y_SKIP) begin
                next_dx = 7'h0;                                            // RQ2
                next_dy = 7'h0;
                next_x0_act = raster_cmd[XC_LSB +: COARSE_W];
                next_y0_act = raster_cmd[YC_LSB +: COARSE_W];
                next_szx = raster_cmd[SZ_LSB +: SIZE_W];
                next_szy = raster_cmd[SZ_LSB +: SIZE_W];
                next_blank = 1'b1;
            end
        end else if (state == ST_SEARCH && dwell_end) begin
            if (blank) begin
                next_blank = 1'b0;
            end else if (acquire) begin
                next_state = ST_TRACK;                                     // RQ21
                next_presence = 1'b1;
                next_acq_dx = dx;
                next_acq_dy = dy;
            end else if (!line_end) begin
                next_dx = dx + 7'h1;                                       // RQ15 RQ9
            end else begin
                next_dx = 7'h0;                                            // RQ17
                next_blank = 1'b1;
                next_x0_act = raster_cmd[XC_LSB +: COARSE_W];              // RQ5
                next_szx = raster_cmd[SZ_LSB +: SIZE_W];
                if (field_end) begin
                    next_dy = 7'h0;                                        // RQ2
                    next_y0_act = raster_cmd[YC_LSB +: COARSE_W];          // RQ5
                    next_szy = raster_cmd[SZ_LSB +: SIZE_W];
                end else begin
                    next_dy = dy + 7'h1;                                   // RQ17
                end
            end
        end
    end

    // coarse is signed; X counts up along a line, Y steps down per line
    assign cx = {x0_act[6], x0_act} + {1'b0, dx};                          // RQ12 RQ15
    assign cy = {y0_act[6], y0_act} - {1'b0, dy};
    // freeze errors while the track loop has lost the star
    assign next_ex = (state == ST_TRACK && !track_star_ok) ? ex : track_err_x; // RQ8
    assign next_ey = (state == ST_TRACK && !track_star_ok) ? ey : track_err_y; // RQ8

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            x0_act <= 7'h0;
            y0_act <= 7'h0;
            szx <= 6'h0;
            szy <= 6'h0;
            dx <= 7'h0;
            dy <= 7'h0;
            acq_dx <= 7'h0;
            acq_dy <= 7'h0;
            mode_act <= MODE_PRIMARY;
            blank <= 1'b1;
            presence <= 1'b0;
            timer <= 15'h0;
            ex <= 12'h0;
            ey <= 12'h0;
            scan_x <= 12'h0;
            scan_y <= 12'h0;
        end else begin
            state <= next_state;
            x0_act <= next_x0_act;
            y0_act <= next_y0_act;
            szx <= next_szx;
            szy <= next_szy;
            dx <= next_dx;
            dy <= next_dy;
            acq_dx <= next_acq_dx;
            acq_dy <= next_acq_dy;
            mode_act <= next_mode_act;
            blank <= next_blank;
            presence <= next_presence;
            timer <= next_timer;
            ex <= next_ex;
            ey <= next_ey;
            scan_x <= {cx[6:0], raster_cmd[XF_LSB +: FINE_W]};             // RQ4 RQ11
            scan_y <= {cy[6:0], raster_cmd[YF_LSB +: FINE_W]};             // RQ4 RQ11
        end
    end

    assign track_active = (state == ST_TRACK);
    assign track_hold = track_active && !track_star_ok;                    // RQ8
    assign track_scan_rate_bit = ctrl_cmd[RATE_BIT];                       // RQ7
    assign scan_spacing_bit = ctrl_cmd[SPACE_BIT];                         // RQ7
    assign star_presence_flag = presence;
    assign err_x_out = ex;
    assign err_y_out = ey;

    // ==========================================================
    // telemetry word: mode, X, Y, magnitude, presence, errors
    logic [TLM_W-1:0] tlm_word;
    assign tlm_word = {mode_act, scan_x[11:5], scan_y[11:5],               // RQ16
                       (blank ? 15'h0 : mag_count), presence, ex, ey};     // RQ17
    sfrs_tlm_shift #(.W(TLM_W)) u_tlm (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (gate_p),
        .shift   (shift_p),
        .word    (tlm_word),
        .sdata   (tlm_sdata)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_cont_trk;
        state == ST_TRACK && cont_req && !mode_chg && acq_dy + Y_SKIP <= y_lim
        |=> state == ST_SEARCH && dy == $past(acq_dy) + Y_SKIP && dx == $past(acq_dx);
    endproperty
    a_cont_trk: assert property (p_cont_trk) else $error("continue from track misplaced"); // RQ1
    property p_cont_srch;
        state == ST_SEARCH && cont_req && !mode_chg && dy + Y_SKIP <= y_lim
        |=> dy == $past(dy) + Y_SKIP;
    endproperty
    a_cont_srch: assert property (p_cont_srch) else $error("search skip wrong"); // RQ3
    property p_restart;
        state == ST_SEARCH && dwell_end && !blank && !acquire && line_end && field_end
        && !mode_chg && !cont_req |=> dx == 7'h0 && dy == 7'h0 && blank;
    endproperty
    a_restart: assert property (p_restart) else $error("raster not restarted"); // RQ2
    property p_fine;
        $changed(raster_cmd[XF_LSB +: FINE_W]) |=> scan_x[4:0] == $past(raster_cmd[XF_LSB +: FINE_W]);
    endproperty
    a_fine: assert property (p_fine) else $error("fine offset delayed"); // RQ4
    property p_coarse;
        $changed(x0_act) |-> $past(line_end || mode_chg || cont_req);
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse X changed mid line"); // RQ5
    property p_trk_mode;
        state == ST_TRACK && !cont_req |=> mode_act == $past(mode_act) && x0_act == $past(x0_act);
    endproperty
    a_trk_mode: assert property (p_trk_mode) else $error("track took other fields"); // RQ7
    property p_freeze;
        state == ST_TRACK && !track_star_ok ##1 state == ST_TRACK |-> $stable(err_x_out) && $stable(err_y_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("errors moved without star"); // RQ8
    property p_gate_step;
        state == ST_SEARCH && mode_act[1] && gate_p && !blank && !acquire && !line_end
        && !mode_chg && !cont_req |=> dx == $past(dx) + 7'h1;
    endproperty
    a_gate_step: assert property (p_gate_step) else $error("gate did not step"); // RQ9
    property p_map_only;
        state == ST_SEARCH && mode_act[1] && !ctrl_cmd[PERMIT_BIT] |=> state != ST_TRACK;
    endproperty
    a_map_only: assert property (p_map_only) else $error("map only entered track"); // RQ10
    property p_bounds;
        state != ST_IDLE |-> dx <= x_lim && dy <= y_lim;
    endproperty
    a_bounds: assert property (p_bounds) else $error("raster index outside raster"); // RQ13
    c_acquire: cover property (state == ST_SEARCH ##1 state == ST_TRACK);
    c_cont: cover property (state == ST_TRACK && cont_req);
    c_wrap: cover property (line_end && field_end && dwell_end && !blank);
endmodule : sfrs_ctrl
`default_nettype wire

// file: rtl/sfrs_pkg.sv
// package of offsets, field layouts and timing for the raster search control
`default_nettype none
package sfrs_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] REG_RASTER = 8'h00;
    localparam logic [7:0] REG_CTRL   = 8'h04;
    localparam logic [7:0] REG_CONT   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_POS    = 8'h10;
    localparam logic [7:0] REG_MAG    = 8'h14;
    // ==========================================================
    // raster command fields
    localparam int XC_LSB = 0;
    localparam int XF_LSB = 7;
    localparam int YC_LSB = 12;
    localparam int YF_LSB = 19;
    localparam int SZ_LSB = 24;
    localparam int COARSE_W = 7;
    localparam int FINE_W   = 5;
    localparam int SIZE_W   = 6;
    localparam int COORD_W  = 12;
    localparam int MAG_W    = 15;
    localparam int TLM_W    = 56;
    // control command fields
    localparam int MODE_LSB = 0;
    localparam int PERMIT_BIT = 2;
    localparam int RATE_BIT = 3;
    localparam int SPACE_BIT = 4;
    localparam int THR_SEL_LSB = 5;
    localparam logic [31:0] RASTER_RST = 32'h0000_0000;
    localparam logic [6:0]  CTRL_RST   = 7'h00;
    // ==========================================================
    // modes and states
    localparam logic [1:0] MODE_PRIMARY = 2'b00;
    localparam logic [1:0] MODE_SEARCH  = 2'b01;
    localparam logic [6:0] Y_SKIP = 7'h02;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SEARCH = 2'b01,
        ST_TRACK  = 2'b11
    } sfrs_state_e;
    // ==========================================================
    // timing: internal search dwell
    localparam int CLK_NS   = 100;
    localparam int DWELL_NS = 2400000;
    localparam int DWELL_CYC = DWELL_NS / CLK_NS;
    // acquisition thresholds in magnitude counts, code 00 dimmest
    localparam logic [14:0] THR_0 = 15'h0100;
    localparam logic [14:0] THR_1 = 15'h0280;
    localparam logic [14:0] THR_2 = 15'h0640;
    localparam logic [14:0] THR_3 = 15'h1000;
endpackage : sfrs_pkg
`default_nettype wire

// file: rtl/sfrs_tlm_shift.sv
// serial telemetry word shifter, loaded on each word gate
`timescale 1ns/10ps
`default_nettype none
module sfrs_tlm_shift
    import sfrs_pkg::*;
#(
    parameter int W = TLM_W
) (
    input  wire logic         hclk,     // clock
    input  wire logic         hresetn,  // async reset, active low
    input  wire logic         load,     // word gate pulse
    input  wire logic         shift,    // shift pulse
    input  wire logic [W-1:0] word,     // parallel word
    output logic              sdata     // serial data, msb first
);
    logic [W-1:0] sr;
    logic [W-1:0] next_sr;

    always_comb begin
        next_sr = sr;
        if (load) begin
            next_sr = word;
        end else if (shift) begin
            next_sr = {sr[W-2:0], 1'b0};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sr <= '0;
        end else begin
            sr <= next_sr;
        end
    end

    assign sdata = sr[W-1];
endmodule : sfrs_tlm_shift
`default_nettype wire

// file: testbench/sfrs_tdu_model.sv
// telemetry data unit model: word gates, shift pulses and serial capture
`timescale 1ns/10ps
`default_nettype none
module sfrs_tdu_model (
    input  wire logic   hclk,      // clock
    input  wire logic   run,       // start one word cycle
    input  wire logic   tlm_sdata, // serial telemetry in
    output logic        gate,      // word gate
    output logic        shift,     // shift pulse
    output logic [55:0] word,      // captured word
    output int          words      // words captured so far
);
    // gate always precedes the shifts; a bit is taken before each shift, msb first
    initial begin
        gate = 1'b0;
        shift = 1'b0;
        word = 56'h0;
        words = 0;
        forever begin
            @(posedge hclk);
            if (run) begin
                gate <= 1'b1;
                repeat (3) @(posedge hclk);
                gate <= 1'b0;
                repeat (6) @(posedge hclk);
                for (int i = 0; i < 56; i++) begin
                    word <= {word[54:0], tlm_sdata};
                    shift <= 1'b1;
                    repeat (2) @(posedge hclk);
                    shift <= 1'b0;
                    repeat (4) @(posedge hclk);
                end
                words <= words + 1;
            end
        end
    end
endmodule : sfrs_tdu_model
`default_nettype wire

// file: testbench/star_field_raster_search_control_tb.sv
// testbench for the search raster control
`timescale 1ns/10ps
`default_nettype none
module star_field_raster_search_control_tb
    import sfrs_pkg::*;
;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
    logic        star_ok = 1'b1, hreadyout, hresp, sdata, gate, shift, act, hold, rate, space, pres;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata, seed = 32'h0001_7a34;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [14:0] mag = 15'h0, thr [4];
    logic [11:0] ex = 12'h0, ey = 12'h0, sx, sy, eox, eoy;
    logic [23:0] held;
    logic [6:0]  cx, cy, cx2;
    logic [4:0]  fx;
    logic [55:0] tlm;
    int          failures = 0, total_checks = 0, words, w0, qx[$], qy[$];
    always #50 hclk = ~hclk;
    sfrs_ctrl #(.DWELL_CYCLES(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .telemetry_word_gate(gate), .tlm_shift_pin(shift), .tlm_sdata(sdata), .mag_count(mag),
        .track_star_ok(star_ok), .track_err_x(ex), .track_err_y(ey), .scan_x(sx), .scan_y(sy),
        .track_active(act), .track_hold(hold), .track_scan_rate_bit(rate),
        .scan_spacing_bit(space), .star_presence_flag(pres), .err_x_out(eox), .err_y_out(eoy));
    sfrs_tdu_model tdu (.hclk(hclk), .run(run), .tlm_sdata(sdata), .gate(gate), .shift(shift),
        .word(tlm), .words(words));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic end_sim;
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        repeat (30000) @(posedge hclk);
        failures++;
        end_sim();
    end
    initial begin
        thr = '{THR_0, THR_1, THR_2, THR_3};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0080);
        chk(hresp, 1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        // map-only field mode, negative coarse X start, 3 x 3 raster
        cx = 7'h7d;
        cy = 7'h05;
        cx2 = cx + 7'h10;
        seed = lfsr(seed);
        fx = seed[4:0];
        mag <= 15'h7fff;
        bus(1'b1, REG_RASTER, {8'h01, 5'h00, cy, fx, cx});
        bus(1'b1, REG_CTRL, 32'h02);
        for (int j = 0; j < 3; j++) for (int i = -1; i < 3; i++) begin
            qx.push_back(i < 0 ? 0 : i);
            qy.push_back(j);
        end
        qx.push_back(0);
        qy.push_back(0);
        for (int n = 0; n < 13; n++) begin
            if (n == 2) begin
                seed = lfsr(seed);
                fx = seed[4:0];
                bus(1'b1, REG_RASTER, {8'h01, 5'h00, cy, fx, cx2});
                repeat (3) @(posedge hclk);
                chk(sx[4:0], fx);
            end
            repeat (5) @(posedge hclk);
            chk(sx, {(n >= 4 ? cx2 : cx) + 7'(qx[n]), fx});
            chk(sy, {cy - 7'(qy[n]), 5'h00});
            chk(pres, 1'b0);
            w0 = words;
            run <= 1'b1;
            @(posedge hclk);
            run <= 1'b0;
            while (words == w0) @(posedge hclk);
            chk({tlm[55:54], tlm[24]}, 3'b100);
            chk(tlm[55:25], {2'b10, (n >= 4 ? cx2 : cx) + 7'(qx[n]), cy - 7'(qy[n]),
                ((n % 4 == 0) ? 15'h0 : 15'h7fff)});
        end
        // search and track: every threshold code, then hold, continue from track and search
        bus(1'b1, REG_RASTER, {8'h0a, 5'h00, 7'h14, 5'h00, 7'h02});
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, REG_CTRL, 32'h0);
            mag <= thr[c];
            bus(1'b1, REG_CTRL, {c[1:0], 5'h01});
            repeat (100) @(posedge hclk);
            chk(pres, 1'b0);
            mag <= thr[c] + 15'h1;
            for (int i = 0; i < 60 && pres !== 1'b1; i++) @(posedge hclk);
            chk({pres, act}, 2'b11);
            bus(1'b1, REG_CTRL, {c[1:0], 5'h19});
            @(posedge hclk);
            chk({rate, space, act}, 3'b111);
            seed = lfsr(seed);
            ex <= seed[11:0];
            ey <= seed[23:12];
            repeat (3) @(posedge hclk);
            chk({eox, eoy}, {seed[11:0], seed[23:12]});
            held = {eox, eoy};
            star_ok <= 1'b0;
            ex <= ~seed[11:0];
            ey <= ~seed[23:12];
            repeat (4) @(posedge hclk);
            chk({hold, eox, eoy}, {1'b1, held});
            star_ok <= 1'b1;
            mag <= 15'h0;
            bus(1'b1, REG_CONT, 32'h0);
            repeat (3) @(posedge hclk);
            chk({pres, act, sy[11:5]}, {2'b00, 7'h12});
            repeat (30) @(posedge hclk);
            bus(1'b1, REG_CONT, 32'h0);
            repeat (3) @(posedge hclk);
            chk(sy[11:5], 7'h10);
        end
        // field mode with permit: second word gate, past the blank dwell, hands over to track
        bus(1'b1, REG_CTRL, 32'h0);
        mag <= 15'h7fff;
        bus(1'b1, REG_CTRL, 32'h06);
        for (int k = 0; k < 2; k++) begin
            chk(pres, 1'b0);
            w0 = words;
            run <= 1'b1;
            @(posedge hclk);
            run <= 1'b0;
            while (words == w0) @(posedge hclk);
        end
        chk({pres, act}, 2'b11);
        end_sim();
    end
endmodule : star_field_raster_search_control_tb
`default_nettype wire
